// ==== rtl/mrsa_byte_fmt.sv ====
// Picks one read byte out of a snapshot for a given format and index.
// Pure combinational; the caller registers the result.
`default_nettype none

module mrsa_byte_fmt
  import mrsa_pkg::*;
(
  // Selection
  input wire mrsa_fmt_t   fmt,
  input wire logic [1:0]  index,
  // Snapshot
  input wire logic [11:0] volt,
  input wire logic [11:0] curr,
  input wire logic [7:0]  status,
  // Result
  output logic [7:0]      byte_out
);

  // Bytes past the end read as a fixed filler
  always_comb
  begin
    byte_out = RD_PAST_END;
    unique case (fmt)
      MRSA_FMT_BOTH:
        unique case (index)
          2'h0:    byte_out = volt[11:4];
          2'h1:    byte_out = curr[11:4];
          2'h2:    byte_out = {volt[3:0], curr[3:0]};
          default: byte_out = RD_PAST_END;
        endcase
      MRSA_FMT_VOLT:
        unique case (index)
          2'h0:    byte_out = volt[11:4];
          2'h1:    byte_out = {volt[3:0], 4'h0};
          default: byte_out = RD_PAST_END;
        endcase
      MRSA_FMT_CURR:
        unique case (index)
          2'h0:    byte_out = curr[11:4];
          2'h1:    byte_out = {curr[3:0], 4'h0};
          default: byte_out = RD_PAST_END;
        endcase
      MRSA_FMT_STATUS:
        byte_out = (index == 2'h0) ? status : RD_PAST_END;
    endcase
  end

endmodule : mrsa_byte_fmt

`default_nettype wire

// ==== rtl/mrsa_conv_if.sv ====
// Conversion results passed from the top to its trip detector.
// Assumes both ends sit on the same clock.
`default_nettype none

interface mrsa_conv_if;
  logic        i_valid;
  logic [11:0] i_data;
  logic [7:0]  trip_level;
  logic        live;
  logic        single_hit;
  logic        quad_hit;

  modport src  (output i_valid, output i_data, output trip_level,
                input live, input single_hit, input quad_hit);
  modport sink (input i_valid, input i_data, input trip_level,
                output live, output single_hit, output quad_hit);
endinterface : mrsa_conv_if

`default_nettype wire

// ==== rtl/mrsa_pkg.sv ====
// Constants, field layouts and encodings for the monitor readback and alert block.
// Assumes one synchronous clock domain; no other file defines these names.
//
// Overview of operation
// - Force-off bit shuts down like enable low
// - Dual read: V hi, I hi, V/I nibbles
// - Voltage read: V hi, V lo nibble+zeros
// - Current read: I hi, I lo nibble+zeros
// - Status select returns one status byte
// - Status bit0: last three conversions over
// - Status bit1 latches conversion trip alert
// - Status bit2 shows live analog overcurrent off
// - Status bit3 latches any hot swap failure
// - Status bit4: enable low or force-off
// - Status bit5 latches off-caused alert
// - Clear bit resets status bits 1,3,5
// - Open-drain alert low on enabled latch
// - Alert idle after power-up until enabled
// - Level reset all ones, vs current[11:4]
// - Enable bit0 single, bit1 four conversions
// - Clear bit self-clears after clearing
// - Command bit6 selects status readback
`default_nettype none

package mrsa_pkg;

  // Extended register selectors
  localparam logic [1:0] EXT_ALERT_EN = 2'h1;
  localparam logic [1:0] EXT_TRIP_LVL = 2'h2;
  localparam logic [1:0] EXT_CONTROL  = 2'h3;

  // Command byte fields
  localparam int CMD_V_CONT = 0;
  localparam int CMD_V_ONCE = 1;
  localparam int CMD_I_CONT = 2;
  localparam int CMD_I_ONCE = 3;
  localparam int CMD_STATUS = 6;
  localparam logic [7:0] CMD_RESET = 8'h00;

  // Alert-enable fields
  localparam int AEN_SINGLE = 0;
  localparam int AEN_QUAD   = 1;
  localparam int AEN_SWAP   = 2;
  localparam int AEN_OFF    = 3;
  localparam int AEN_CLEAR  = 4;
  localparam logic [3:0] AEN_RESET = 4'h4;

  // Control and threshold
  localparam int CTL_FORCE_OFF = 0;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] LVL_RESET = 8'hff;

  // Status byte fields
  localparam int ST_CONV_LIVE  = 0;
  localparam int ST_CONV_LATCH = 1;
  localparam int ST_SWAP_OC    = 2;
  localparam int ST_SWAP_FAIL  = 3;
  localparam int ST_OFF_STATE  = 4;
  localparam int ST_OFF_LATCH  = 5;

  // Trip history depths
  localparam int LIVE_DEPTH = 3;
  localparam logic [2:0] QUAD_COUNT = 3'h4;

  // Read formats
  typedef enum logic [1:0]
  {
    MRSA_FMT_BOTH   = 2'b00,
    MRSA_FMT_VOLT   = 2'b01,
    MRSA_FMT_CURR   = 2'b10,
    MRSA_FMT_STATUS = 2'b11
  } mrsa_fmt_t;

  localparam logic [1:0] LEN_BOTH   = 2'h3;
  localparam logic [1:0] LEN_SINGLE = 2'h2;
  localparam logic [1:0] LEN_STATUS = 2'h1;
  localparam logic [7:0] RD_PAST_END = 8'h00;

  // Byte count of each format
  function automatic logic [1:0] mrsa_fmt_len(input mrsa_fmt_t fmt);
    unique case (fmt)
      MRSA_FMT_BOTH:   mrsa_fmt_len = LEN_BOTH;
      MRSA_FMT_VOLT:   mrsa_fmt_len = LEN_SINGLE;
      MRSA_FMT_CURR:   mrsa_fmt_len = LEN_SINGLE;
      MRSA_FMT_STATUS: mrsa_fmt_len = LEN_STATUS;
    endcase
  endfunction : mrsa_fmt_len

endpackage : mrsa_pkg

`default_nettype wire

// ==== rtl/mrsa_top.sv ====
// Register side of the power monitor: command, extended registers, readback
// formatting, status flags and the open-drain alert pin.
// Assumes a serial-bus engine on clk_sys hands over decoded write and read
// strobes, and conversion results arrive as same-clock one-cycle strobes.
`default_nettype none

module mrsa_top
  import mrsa_pkg::*;
(
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        reset,
  // Decoded writes from the serial engine
  input wire logic        cmd_wr,
  input wire logic        ext_wr,
  input wire logic [1:0]  ext_sel,
  input wire logic [7:0]  wr_data,
  // Read sequencing from the serial engine
  input wire logic        rd_start,
  input wire logic        rd_next,
  output logic [7:0]      rd_data,
  output logic [1:0]      rd_len,
  // Conversion results
  input wire logic        v_valid,
  input wire logic [11:0] v_data,
  input wire logic        i_valid,
  input wire logic [11:0] i_data,
  // Command channel selects for the converter
  output logic [7:0]      cmd_byte,
  // Hot swap pins and state
  input wire logic        on_pin,
  input wire logic        swap_fault_state,
  input wire logic        swap_failed,
  output logic            swap_shutdown,
  // Open-drain alert pin
  input wire logic        interrupt_out_n_in,
  output logic            interrupt_out_n,
  output logic            interrupt_out_n_oe_n
);

  // Pin synchronisers: enable, analog overcurrent, failure
  logic [2:0] pin_meta_q, pin_sync_q;
  logic       pin_unused;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      pin_meta_q <= 3'h0;
      pin_sync_q <= 3'h0;
    end
    else
    begin
      pin_meta_q <= {swap_failed, swap_fault_state, on_pin};
      pin_sync_q <= pin_meta_q;
    end
  end

  // The pin's read-back level is not needed by this block
  assign pin_unused = interrupt_out_n_in;

  // Configuration registers
  logic [7:0]  cmd_q, cmd_d;
  logic [3:0]  aen_q, aen_d;
  logic [7:0]  lvl_q, lvl_d;
  logic [7:0]  ctl_q, ctl_d;
  logic        clear_q, clear_d;
  logic        armed_q, armed_d;
  logic        aen_wr, ctl_wr;

  assign aen_wr = ext_wr && (ext_sel == EXT_ALERT_EN);
  assign ctl_wr = ext_wr && (ext_sel == EXT_CONTROL);

  // Register writes; clear is held one cycle then drops by itself
  always_comb
  begin
    cmd_d   = cmd_q;
    aen_d   = aen_q;
    lvl_d   = lvl_q;
    ctl_d   = ctl_q;
    clear_d = 1'b0;
    armed_d = armed_q;
    if (cmd_wr)
      cmd_d = {1'b0, wr_data[6:0]};
    if (aen_wr)
    begin
      aen_d   = wr_data[3:0];
      clear_d = wr_data[AEN_CLEAR];
      armed_d = 1'b1;
    end
    if (ext_wr && (ext_sel == EXT_TRIP_LVL))
      lvl_d = wr_data;
    if (ctl_wr)
      ctl_d = wr_data;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      cmd_q   <= CMD_RESET;
      aen_q   <= AEN_RESET;
      lvl_q   <= LVL_RESET;
      ctl_q   <= CTL_RESET;
      clear_q <= 1'b0;
      armed_q <= 1'b0;
    end
    else
    begin
      cmd_q   <= cmd_d;
      aen_q   <= aen_d;
      lvl_q   <= lvl_d;
      ctl_q   <= ctl_d;
      clear_q <= clear_d;
      armed_q <= armed_d;
    end
  end

  // Trip history on the current channel
  mrsa_conv_if conv ();

  assign conv.i_valid    = i_valid;
  assign conv.i_data     = i_data;
  assign conv.trip_level = lvl_q;

  mrsa_trip_detect u_trip (
    .clk_sys (clk_sys),
    .reset   (reset),
    .conv    (conv)
  );

  // Off condition: enable pin low or software force-off
  logic off_now, off_prev_q, fail_prev_q;

  assign off_now = !pin_sync_q[0] || ctl_q[CTL_FORCE_OFF];

  // Latched flags; a set in the clear cycle wins
  logic conv_latch_q, conv_latch_d;
  logic swap_fail_latch_q, swap_fail_latch_d;
  logic off_latch_q, off_latch_d;
  logic conv_set, fail_set, off_set;
  logic alert_q, alert_d, shut_q;

  assign conv_set = (conv.single_hit && aen_q[AEN_SINGLE])
                 || (conv.quad_hit && aen_q[AEN_QUAD]);
  assign fail_set = pin_sync_q[2] && !fail_prev_q;
  assign off_set  = aen_q[AEN_OFF]
                 && ((off_now && !off_prev_q)
                 || (ctl_wr && wr_data[CTL_FORCE_OFF]));

  always_comb
  begin
    conv_latch_d      = conv_latch_q;
    swap_fail_latch_d = swap_fail_latch_q;
    off_latch_d       = off_latch_q;
    if (clear_q)
    begin
      conv_latch_d      = 1'b0;
      swap_fail_latch_d = 1'b0;
      off_latch_d       = 1'b0;
    end
    if (conv_set)
      conv_latch_d = 1'b1;
    if (fail_set)
      swap_fail_latch_d = 1'b1;
    if (off_set)
      off_latch_d = 1'b1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      conv_latch_q      <= 1'b0;
      swap_fail_latch_q <= 1'b0;
      off_latch_q       <= 1'b0;
      off_prev_q        <= 1'b0;
      fail_prev_q       <= 1'b0;
      alert_q           <= 1'b0;
      shut_q            <= 1'b0;
    end
    else
    begin
      conv_latch_q      <= conv_latch_d;
      swap_fail_latch_q <= swap_fail_latch_d;
      off_latch_q       <= off_latch_d;
      off_prev_q        <= off_now;
      fail_prev_q       <= pin_sync_q[2];
      alert_q           <= alert_d;
      shut_q            <= off_now;
    end
  end

  // Status byte: two live bits, one state bit, three latches
  logic [7:0] status_now;

  always_comb
  begin
    status_now                = 8'h00;
    status_now[ST_CONV_LIVE]  = conv.live;
    status_now[ST_CONV_LATCH] = conv_latch_q;
    status_now[ST_SWAP_OC]    = pin_sync_q[1];
    status_now[ST_SWAP_FAIL]  = swap_fail_latch_q;
    status_now[ST_OFF_STATE]  = off_now;
    status_now[ST_OFF_LATCH]  = off_latch_q;
  end

  // Latest conversion results; zero until the first one lands
  logic [11:0] volt_q, volt_d;
  logic [11:0] curr_q, curr_d;

  always_comb
  begin
    volt_d = v_valid ? v_data : volt_q;
    curr_d = i_valid ? i_data : curr_q;
  end

  // Format from the last command's channel and status bits
  mrsa_fmt_t fmt_now;
  logic      want_v, want_i;

  assign want_v = cmd_q[CMD_V_CONT] || cmd_q[CMD_V_ONCE];
  assign want_i = cmd_q[CMD_I_CONT] || cmd_q[CMD_I_ONCE];

  always_comb
  begin
    if (cmd_q[CMD_STATUS])
      fmt_now = MRSA_FMT_STATUS;
    else if (want_v && !want_i)
      fmt_now = MRSA_FMT_VOLT;
    else if (want_i && !want_v)
      fmt_now = MRSA_FMT_CURR;
    else
      fmt_now = MRSA_FMT_BOTH;
  end

  // Read snapshot taken at the start so bytes stay coherent
  mrsa_fmt_t   rd_fmt_q, rd_fmt_d;
  logic [1:0]  rd_idx_q, rd_idx_d;
  logic [11:0] snap_v_q, snap_v_d;
  logic [11:0] snap_i_q, snap_i_d;
  logic [7:0]  snap_s_q, snap_s_d;
  logic [7:0]  rd_data_q, rd_data_d;
  logic [1:0]  fmt_idx, idx_adv;
  mrsa_fmt_t   fmt_sel;
  logic [11:0] sel_v, sel_i;
  logic [7:0]  sel_s;
  logic [7:0]  next_byte;

  // Index sticks at 3 so overreads keep returning filler; taken from the
  assign idx_adv = (rd_idx_q != 2'h3) ? rd_idx_q + 2'h1 : rd_idx_q;
  // On start the live values feed the formatter directly
  assign fmt_sel = rd_start ? fmt_now : rd_fmt_q;
  assign fmt_idx = rd_start ? 2'h0 : idx_adv;
  assign sel_v   = rd_start ? volt_q : snap_v_q;
  assign sel_i   = rd_start ? curr_q : snap_i_q;
  assign sel_s   = rd_start ? status_now : snap_s_q;

  mrsa_byte_fmt u_fmt (
    .fmt      (fmt_sel),
    .index    (fmt_idx),
    .volt     (sel_v),
    .curr     (sel_i),
    .status   (sel_s),
    .byte_out (next_byte)
  );

  always_comb
  begin
    rd_fmt_d  = rd_fmt_q;
    rd_idx_d  = rd_idx_q;
    snap_v_d  = snap_v_q;
    snap_i_d  = snap_i_q;
    snap_s_d  = snap_s_q;
    rd_data_d = rd_data_q;
    if (rd_start)
    begin
      rd_fmt_d  = fmt_now;
      rd_idx_d  = 2'h0;
      snap_v_d  = volt_q;
      snap_i_d  = curr_q;
      snap_s_d  = status_now;
      rd_data_d = next_byte;
    end
    else if (rd_next)
    begin
      rd_idx_d  = idx_adv;
      rd_data_d = next_byte;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      volt_q    <= 12'h000;
      curr_q    <= 12'h000;
      rd_fmt_q  <= MRSA_FMT_BOTH;
      rd_idx_q  <= 2'h0;
      snap_v_q  <= 12'h000;
      snap_i_q  <= 12'h000;
      snap_s_q  <= 8'h00;
      rd_data_q <= 8'h00;
    end
    else
    begin
      volt_q    <= volt_d;
      curr_q    <= curr_d;
      rd_fmt_q  <= rd_fmt_d;
      rd_idx_q  <= rd_idx_d;
      snap_v_q  <= snap_v_d;
      snap_i_q  <= snap_i_d;
      snap_s_q  <= snap_s_d;
      rd_data_q <= rd_data_d;
    end
  end

  // Alert: enabled latches only, and only once software has armed it
  assign alert_d = armed_q
                && ((conv_latch_q && (aen_q[AEN_SINGLE] || aen_q[AEN_QUAD]))
                || (swap_fail_latch_q && aen_q[AEN_SWAP])
                || (off_latch_q && aen_q[AEN_OFF]));

  // Outputs
  assign rd_data              = rd_data_q;
  assign rd_len               = mrsa_fmt_len(rd_fmt_q);
  assign cmd_byte             = cmd_q;
  assign swap_shutdown        = shut_q;
  assign interrupt_out_n      = 1'b0; // Only ever pulls low
  assign interrupt_out_n_oe_n = !alert_q;

endmodule : mrsa_top

`default_nettype wire

// ==== rtl/mrsa_trip_detect.sv ====
// Current-over-threshold history: live three-deep flag and trip pulses.
// Assumes current results arrive as one-cycle valid strobes.
`default_nettype none

module mrsa_trip_detect
  import mrsa_pkg::*;
(
  // Clock and reset
  input wire logic    clk_sys,
  input wire logic    reset,
  // Conversion side
  mrsa_conv_if.sink   conv
);

  logic [LIVE_DEPTH-1:0] hist_q, hist_d;
  logic [2:0]            run_q, run_d;
  logic                  single_q, single_d;
  logic                  quad_q, quad_d;
  logic                  above;

  // Top eight result bits against the level
  assign above = conv.i_data[11:4] > conv.trip_level;

  // History, saturating run length and trip pulses
  always_comb
  begin
    hist_d   = hist_q;
    run_d    = run_q;
    single_d = 1'b0;
    quad_d   = 1'b0;
    if (conv.i_valid)
    begin
      hist_d   = {hist_q[LIVE_DEPTH-2:0], above};
      single_d = above;
      if (!above)
        run_d = 3'h0;
      else if (run_q != QUAD_COUNT)
        run_d = run_q + 3'h1;
      quad_d = above && (run_q + 3'h1 >= QUAD_COUNT);
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      hist_q   <= '0;
      run_q    <= 3'h0;
      single_q <= 1'b0;
      quad_q   <= 1'b0;
    end
    else
    begin
      hist_q   <= hist_d;
      run_q    <= run_d;
      single_q <= single_d;
      quad_q   <= quad_d;
    end
  end

  assign conv.live       = &hist_q;
  assign conv.single_hit = single_q;
  assign conv.quad_hit   = quad_q;

endmodule : mrsa_trip_detect

`default_nettype wire

// ==== verification/mrsa_master_model.sv ====
// Serial-bus master model issuing the decoded write and read strobes.
// Assumes the block samples on rising edges; this model drives on falling ones.
`default_nettype none

module mrsa_master_model
(
  // Clock
  input wire logic       clk_sys,
  // Decoded writes
  output var logic       cmd_wr,
  output var logic       ext_wr,
  output var logic [1:0] ext_sel,
  output var logic [7:0] wr_data,
  // Read sequencing
  output var logic       rd_start,
  output var logic       rd_next,
  input wire logic [7:0] rd_data,
  input wire logic [1:0] rd_len
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle bus at time zero
  initial
  begin
    cmd_wr   = 1'b0;
    ext_wr   = 1'b0;
    ext_sel  = 2'h0;
    wr_data  = 8'h00;
    rd_start = 1'b0;
    rd_next  = 1'b0;
  end

  // One byte; data lines turn to garbage once it is gone
  task automatic wr(input logic ext, input logic [1:0] sel, input logic [7:0] data);
    @(negedge clk_sys);
    cmd_wr  = !ext;
    ext_wr  = ext;
    ext_sel = sel;
    wr_data = data;
    @(negedge clk_sys);
    cmd_wr  = 1'b0;
    ext_wr  = 1'b0;
    ext_sel = ~sel;
    wr_data = ~data;
  endtask : wr

  // Ack every byte but the last, which is nacked before the stop
  task automatic rd(output logic [7:0] b [3], output logic [1:0] n);
    @(negedge clk_sys);
    rd_start = 1'b1;
    @(negedge clk_sys);
    rd_start = 1'b0;
    n        = rd_len;
    b        = '{default: 8'h00};
    b[0]     = rd_data;
    for (int k = 1; k < n; k++)
    begin
      rd_next = 1'b1;
      @(negedge clk_sys);
      b[k] = rd_data;
    end
    rd_next = 1'b0;
  endtask : rd
endmodule : mrsa_master_model

`default_nettype wire

// ==== verification/mrsa_top_assertions.sv ====
// Concurrent checks on the ports of the monitor readback block.
// Assumes one clock domain and the synchronous active-high reset.
`default_nettype none

module mrsa_top_checker
  import mrsa_pkg::*;
(
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        reset,
  // Bus side
  input wire logic        ext_wr,
  input wire logic [1:0]  ext_sel,
  input wire logic [7:0]  wr_data,
  input wire logic        rd_start,
  input wire logic        rd_next,
  input wire logic [7:0]  rd_data,
  input wire logic [1:0]  rd_len,
  input wire logic [7:0]  cmd_byte,
  // Current result and pins
  input wire logic        i_valid,
  input wire logic [11:0] i_data,
  input wire logic        on_pin,
  input wire logic        swap_shutdown,
  input wire logic        interrupt_out_n,
  input wire logic        interrupt_out_n_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;

  logic       armed_q;
  logic       single_q;
  logic [7:0] lvl_q;

  default clocking chk_cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  // Shadow of arming and trip setup, so trip timing can be judged
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      armed_q  <= 1'b0;
      single_q <= 1'b0;
      lvl_q    <= LVL_RESET;
    end
    else if (ext_wr && ext_sel == EXT_ALERT_EN)
    begin
      armed_q  <= 1'b1;
      single_q <= wr_data[AEN_SINGLE];
    end
    else if (ext_wr && ext_sel == EXT_TRIP_LVL)
      lvl_q <= wr_data;
  end

  // Single-channel reads: address phase, then one ack
  sequence volt_rd_s;
    rd_start && !cmd_byte[CMD_STATUS] && cmd_byte[1:0] != 2'h0 && cmd_byte[3:2] == 2'h0
      ##1 rd_next && !rd_start;
  endsequence
  sequence curr_rd_s;
    rd_start && !cmd_byte[CMD_STATUS] && cmd_byte[1:0] == 2'h0 && cmd_byte[3:2] != 2'h0
      ##1 rd_next && !rd_start;
  endsequence

  drive_low_a : assert property (interrupt_out_n == 1'b0)
    else $error("alert pin drives high");
  idle_alert_a : assert property (!armed_q |-> interrupt_out_n_oe_n)
    else $error("alert active before arming");
  force_off_a : assert property (ext_wr && ext_sel == EXT_CONTROL
    && wr_data[CTL_FORCE_OFF] |-> ##[1:2] swap_shutdown)
    else $error("force-off did not shut down");
  pin_off_a : assert property (!on_pin [*5] |=> swap_shutdown)
    else $error("enable low did not shut down");
  status_fmt_a : assert property (rd_start && cmd_byte[CMD_STATUS]
    |=> rd_data[7:6] == 2'h0 && rd_len == LEN_STATUS) else $error("bad status read");
  volt_nib_a : assert property (volt_rd_s |=> rd_data[3:0] == 4'h0 && rd_len == LEN_SINGLE)
    else $error("voltage low nibble not zero");
  curr_nib_a : assert property (curr_rd_s |=> rd_data[3:0] == 4'h0 && rd_len == LEN_SINGLE)
    else $error("current low nibble not zero");
  trip_single_a : assert property (i_valid && single_q && i_data[11:4] > lvl_q
    |-> ##3 !interrupt_out_n_oe_n) else $error("single trip missed");
  clear_idle_a : assert property (ext_wr && ext_sel == EXT_ALERT_EN && wr_data == 8'h10
    |-> ##3 interrupt_out_n_oe_n) else $error("clear left alert active");
endmodule : mrsa_top_checker

bind mrsa_top mrsa_top_checker i_mrsa_top_checker
(
  .clk_sys(clk_sys), .reset(reset), .ext_wr(ext_wr), .ext_sel(ext_sel),
  .wr_data(wr_data), .rd_start(rd_start), .rd_next(rd_next), .rd_data(rd_data),
  .rd_len(rd_len), .cmd_byte(cmd_byte), .i_valid(i_valid), .i_data(i_data),
  .on_pin(on_pin), .swap_shutdown(swap_shutdown), .interrupt_out_n(interrupt_out_n),
  .interrupt_out_n_oe_n(interrupt_out_n_oe_n)
);

`default_nettype wire

// ==== verification/tb_mrsa_top.sv ====
// Self-checking bench for readback formats, status flags and the alert pin.
// Assumes the master model stands in for the serial-bus engine.
`default_nettype none

module tb_mrsa_top
  import mrsa_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [11:0] VR = 12'ha5c;
  localparam logic [11:0] IR = 12'h3b7;
  localparam logic [7:0]  CMDS [7] = '{8'h05, 8'h01, 8'h02, 8'h04, 8'h08, 8'h00, 8'h8f};

  logic        clk_sys, reset, cmd_wr, ext_wr, rd_start, rd_next;
  logic        v_valid, i_valid, on_pin, swap_fault_state, swap_failed;
  logic        swap_shutdown, interrupt_out_n, interrupt_out_n_oe_n;
  logic [1:0]  ext_sel, rd_len, n, el;
  logic [7:0]  wr_data, rd_data, cmd_byte, c;
  logic [11:0] v_data, i_data;
  logic [7:0]  b [3];
  logic [7:0]  e [3];
  int          failures, total_checks;
  wire logic   pin_lvl;

  // Pull-up wins unless the block pulls the pin down
  assign pin_lvl = interrupt_out_n_oe_n ? 1'b1 : interrupt_out_n;

  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  mrsa_top i_mrsa_top (.clk_sys(clk_sys), .reset(reset), .cmd_wr(cmd_wr), .ext_wr(ext_wr),
    .ext_sel(ext_sel), .wr_data(wr_data), .rd_start(rd_start), .rd_next(rd_next),
    .rd_data(rd_data), .rd_len(rd_len), .v_valid(v_valid), .v_data(v_data),
    .i_valid(i_valid), .i_data(i_data), .cmd_byte(cmd_byte), .on_pin(on_pin),
    .swap_fault_state(swap_fault_state), .swap_failed(swap_failed),
    .swap_shutdown(swap_shutdown), .interrupt_out_n_in(pin_lvl),
    .interrupt_out_n(interrupt_out_n), .interrupt_out_n_oe_n(interrupt_out_n_oe_n));

  mrsa_master_model i_mrsa_master_model (.clk_sys(clk_sys), .cmd_wr(cmd_wr),
    .ext_wr(ext_wr), .ext_sel(ext_sel), .wr_data(wr_data), .rd_start(rd_start),
    .rd_next(rd_next), .rd_data(rd_data), .rd_len(rd_len));

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic summarize;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize

  // Data lines hold garbage outside the strobe, as a real converter would
  task automatic conv(input logic [11:0] v, input logic [11:0] i);
    @(negedge clk_sys);
    v_valid = 1'b1;
    i_valid = 1'b1;
    v_data  = v;
    i_data  = i;
    @(negedge clk_sys);
    v_valid = 1'b0;
    i_valid = 1'b0;
    v_data  = ~v;
    i_data  = ~i;
  endtask : conv

  // Settle synchronisers, read one status byte, look at the pin
  task automatic status(input logic [7:0] exp, input logic alert_hi);
    repeat (5) @(negedge clk_sys);
    i_mrsa_master_model.rd(b, n);
    check("status len", 8'h01, {6'h0, n});
    check("status", exp, b[0]);
    check("alert pin", {7'h0, alert_hi}, {7'h0, pin_lvl});
  endtask : status

  // Main sequence
  initial
  begin
    reset            = 1'b1;
    on_pin           = 1'b1;
    swap_fault_state = 1'b0;
    swap_failed      = 1'b0;
    v_valid          = 1'b0;
    i_valid          = 1'b0;
    v_data           = 12'h000;
    i_data           = 12'h000;
    failures         = 0;
    total_checks     = 0;
    repeat (12) @(negedge clk_sys);
    reset = 1'b0;
    repeat (5) @(negedge clk_sys);
    check("rd_len", {6'h0, LEN_BOTH}, {6'h0, rd_len});
    check("cmd_byte", CMD_RESET, cmd_byte);
    check("shutdown", 8'h00, {7'h0, swap_shutdown});
    check("alert pin", 8'h01, {7'h0, pin_lvl});
    // Every channel mode, then bit7 forced low
    conv(VR, IR);
    foreach (CMDS[j])
    begin
      c = CMDS[j];
      i_mrsa_master_model.wr(1'b0, 2'h0, c);
      i_mrsa_master_model.rd(b, n);
      el = 2'h2;
      if (c[1:0] != 2'h0 && c[3:2] == 2'h0)
        e = '{VR[11:4], {VR[3:0], 4'h0}, 8'h00};
      else if (c[1:0] == 2'h0 && c[3:2] != 2'h0)
        e = '{IR[11:4], {IR[3:0], 4'h0}, 8'h00};
      else
      begin
        e  = '{VR[11:4], IR[11:4], {VR[3:0], IR[3:0]}};
        el = 2'h3;
      end
      check("cmd_byte", {1'b0, c[6:0]}, cmd_byte);
      check("rd_len", {6'h0, el}, {6'h0, n});
      for (int k = 0; k < 3; k++)
        check("rd byte", (k < el) ? e[k] : 8'h00, b[k]);
    end
    // Off alerts by control bit and by the enable pin
    i_mrsa_master_model.wr(1'b0, 2'h0, 8'h40);
    status(8'h00, 1'b1);
    i_mrsa_master_model.wr(1'b1, EXT_ALERT_EN, 8'h08);
    i_mrsa_master_model.wr(1'b1, EXT_CONTROL, 8'h01);
    status(8'h30, 1'b0);
    check("shutdown", 8'h01, {7'h0, swap_shutdown});
    i_mrsa_master_model.wr(1'b1, EXT_CONTROL, 8'h00);
    status(8'h20, 1'b0);
    i_mrsa_master_model.wr(1'b1, EXT_ALERT_EN, 8'h18);
    status(8'h00, 1'b1);
    on_pin = 1'b0;
    status(8'h30, 1'b0);
    check("shutdown", 8'h01, {7'h0, swap_shutdown});
    on_pin = 1'b1;
    status(8'h20, 1'b0);
    i_mrsa_master_model.wr(1'b1, EXT_ALERT_EN, 8'h10);
    status(8'h00, 1'b1);
    // Conversion trips: boundary, single, live history, quad
    i_mrsa_master_model.wr(1'b1, EXT_TRIP_LVL, 8'h80);
    i_mrsa_master_model.wr(1'b1, EXT_ALERT_EN, 8'h01);
    conv(VR, 12'h80f);
    status(8'h00, 1'b1);
    conv(VR, 12'h810);
    status(8'h02, 1'b0);
    repeat (2) conv(VR, 12'h810);
    status(8'h03, 1'b0);
    conv(VR, 12'h000);
    status(8'h02, 1'b0);
    i_mrsa_master_model.wr(1'b1, EXT_ALERT_EN, 8'h12);
    repeat (3) conv(VR, 12'hfff);
    status(8'h01, 1'b1);
    conv(VR, 12'hfff);
    status(8'h03, 1'b0);
    // Hot swap fault flags, live and latched
    i_mrsa_master_model.wr(1'b1, EXT_ALERT_EN, 8'h10);
    conv(VR, 12'h000);
    swap_fault_state = 1'b1;
    swap_failed      = 1'b1;
    status(8'h0c, 1'b1);
    swap_fault_state = 1'b0;
    swap_failed      = 1'b0;
    status(8'h08, 1'b1);
    i_mrsa_master_model.wr(1'b1, EXT_ALERT_EN, 8'h04);
    status(8'h08, 1'b0);
    i_mrsa_master_model.wr(1'b1, EXT_ALERT_EN, 8'h14);
    status(8'h00, 1'b1);
    summarize();
  end

  // Watchdog, far beyond the roughly 220 cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    $display("Error watchdog expected done seen hang");
    summarize();
  end
endmodule : tb_mrsa_top

`default_nettype wire
